// >>> rtl/loopback_pkg.sv
// Purpose: Shared constants and types for the loopback test frame logic.
// Assumes: 8-bit management registers addressed by an 8-bit register number.
// Notes: Frame lengths include the four-byte frame check sequence.
package loopback_pkg;
    // Register numbers of the management map.
    localparam logic [7:0] ADDR_SETUP1 = 8'h44;
    localparam logic [7:0] ADDR_PATTERN = 8'h45;
    localparam logic [7:0] ADDR_CRC_CNT = 8'h46;
    localparam logic [7:0] ADDR_MAC0 = 8'h52;
    localparam logic [7:0] ADDR_MAC5 = 8'h57;
    // Reset values and the counter limit.
    localparam logic [7:0] SETUP1_RESET = 8'h07;
    localparam logic [7:0] PATTERN_RESET = 8'h00;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] MAC_RESET = 8'h00;
    // Pattern selector codes.
    localparam logic [7:0] SEL_U64_55AA = 8'h00;
    localparam logic [7:0] SEL_U1518_55AA = 8'h01;
    localparam logic [7:0] SEL_B64_55AA = 8'h02;
    localparam logic [7:0] SEL_B1518_55AA = 8'h04;
    localparam logic [7:0] SEL_U64_0F0F = 8'h08;
    localparam logic [7:0] SEL_U1518_0F0F = 8'h10;
    localparam logic [7:0] SEL_X64_0F0F = 8'h20;
    localparam logic [7:0] SEL_B1518_0F0F = 8'h40;
    localparam logic [7:0] SEL_B1518_FF00 = 8'h80;
    // Payload words, high byte sent first.
    localparam logic [15:0] PAT_55AA = 16'h55AA;
    localparam logic [15:0] PAT_0F0F = 16'h0F0F;
    localparam logic [15:0] PAT_FF00 = 16'hFF00;
    // Frame layout.
    localparam logic [10:0] LEN_SHORT = 11'h040;
    localparam logic [10:0] LEN_LONG = 11'h5EE;
    localparam logic [10:0] FCS_BYTES = 11'h004;
    localparam logic [10:0] IDX_SA = 11'h006;
    localparam logic [10:0] IDX_TYPE_HI = 11'h00C;
    localparam logic [10:0] IDX_TYPE_LO = 11'h00D;
    localparam logic [10:0] IDX_DA_LAST = 11'h005;
    localparam logic [7:0] TYPE_HI = 8'h08;
    localparam logic [7:0] TYPE_LO = 8'h00;
    localparam logic [7:0] BCAST_BYTE = 8'hFF;
    // Frame check sequence.
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } tx_state_t;

    typedef struct packed {
        logic valid;
        logic bcast;
        logic long_frame;
        logic [15:0] pattern;
    } frame_fmt_t;
endpackage

// >>> rtl/frame_crc32.sv
// Purpose: Running Ethernet CRC-32 over a byte stream.
// Assumes: Bytes enter least significant bit first, reflected polynomial.
// Notes: crc_nxt is combinational so the caller can use the final value at once.
`timescale 1ns/1ps
module frame_crc32
    import loopback_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic init,
    input wire logic en,
    input wire logic [7:0] data,
    output logic [31:0] crc_r,
    output logic [31:0] crc_nxt
);
    typedef struct packed {
        logic [31:0] crc;
    } crc_state_t;

    crc_state_t s_r;
    crc_state_t s_nxt;

    // One byte of the reflected CRC, bit by bit.
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = ((r[0] ^ d[i]) != 1'b0) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // The value including the byte being accepted now.
    assign crc_nxt = crc_byte(s_r.crc, data);
    assign crc_r = s_r.crc;

    // Init wins over enable, so a new frame never inherits an old sum.
    always_comb begin
        s_nxt = s_r;
        if (init) begin
            s_nxt.crc = CRC_INIT;
        end else if (en) begin
            s_nxt.crc = crc_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_r <= '{crc: CRC_INIT};
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// >>> rtl/loopback_test_frames.sv
// Purpose: Center-side loopback test frame generator and CRC error counter.
// Assumes: Register port and receive checker run on clock; center_mode is a pin.
// Notes: Frames leave as a byte stream with valid/ready; no gap is inserted.
// Contract
// - Eight-bit read/write pattern selector, reset zero, used only in center mode.
// - Code 00h gives 64-byte unicast, 01h 1518-byte unicast, payload 55AA.
// - Code 02h gives 64-byte broadcast, 04h 1518-byte broadcast, payload 55AA.
// - Code 08h gives 64-byte unicast, 10h 1518-byte unicast, payload 0F0F.
// - Code 20h gives 64-byte frame with payload 0F0F.
// - Code 40h gives 1518-byte broadcast frame with payload 0F0F.
// - Code 80h gives 1518-byte broadcast frame with payload FF00.
// - Destination is address bytes 52h..56h then byte 57h plus one.
// - Last destination byte rises by one for each further frame of a burst.
// - Source built from stored address bytes; type field is 0800h.
// - In center mode, count returned loopback frames with CRC error.
// - Counter value equals the number of errored returned frames.
// - Writing zero to setup register 44h clears the error counter.
// - Counter spans up to FFh, that is 255 errored frames.
// - Frames per burst equal the count written to 44h, default seven.
`timescale 1ns/1ps
module loopback_test_frames
    import loopback_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic center_mode,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_sof,
    output logic tx_eof,
    input wire logic tx_ready,
    input wire logic rx_frame_done,
    input wire logic rx_crc_err,
    output logic busy
);
    typedef struct packed {
        logic center_meta;
        logic center;
        logic [7:0] setup1;
        logic [7:0] pattern_sel;
        logic [7:0] crc_cnt;
        logic [5:0][7:0] mac;
        logic [7:0] rdata;
        logic rvalid;
        tx_state_t st;
        frame_fmt_t fmt;
        logic [10:0] idx;
        logic [7:0] frames_left;
        logic [7:0] da_last;
        logic [7:0] data;
    } lb_state_t;

    lb_state_t s_r;
    lb_state_t s_nxt;
    logic hs;
    logic crc_init;
    logic crc_en;
    logic [31:0] crc_r;
    logic [31:0] crc_nxt;
    logic [10:0] last_idx;
    logic [10:0] last_data_idx;
    logic start;
    logic clear_cnt;
    logic crc_event;
    frame_fmt_t sel_fmt;

    // Map a selector code to its frame format; unlisted codes are not valid.
    function automatic frame_fmt_t decode_sel(input logic [7:0] sel);
        frame_fmt_t f;
        f = '{valid: 1'b1, bcast: 1'b0, long_frame: 1'b0, pattern: PAT_55AA};
        unique case (sel)
            SEL_U64_55AA: f.long_frame = 1'b0;
            SEL_U1518_55AA: f.long_frame = 1'b1;
            SEL_B64_55AA: f.bcast = 1'b1;
            SEL_B1518_55AA: begin
                f.bcast = 1'b1;
                f.long_frame = 1'b1;
            end
            SEL_U64_0F0F: f.pattern = PAT_0F0F;
            SEL_U1518_0F0F: begin
                f.pattern = PAT_0F0F;
                f.long_frame = 1'b1;
            end
            SEL_X64_0F0F: f.pattern = PAT_0F0F;
            SEL_B1518_0F0F: begin
                f = '{valid: 1'b1, bcast: 1'b1, long_frame: 1'b1, pattern: PAT_0F0F};
            end
            SEL_B1518_FF00: begin
                f = '{valid: 1'b1, bcast: 1'b1, long_frame: 1'b1, pattern: PAT_FF00};
            end
            default: f.valid = 1'b0;
        endcase
        return f;
    endfunction

    function automatic logic [10:0] frame_len(input frame_fmt_t f);
        return f.long_frame ? LEN_LONG : LEN_SHORT;
    endfunction

    // Byte at position i of the frame; FCS bytes come from the CRC unit.
    function automatic logic [7:0] frame_byte(input logic [10:0] i, input frame_fmt_t f,
                                             input logic [5:0][7:0] m, input logic [7:0] da,
                                             input logic [31:0] c_nxt, input logic [31:0] c_reg);
        logic [10:0] fcs0;
        logic [10:0] k;
        logic [7:0] b;
        fcs0 = frame_len(f) - FCS_BYTES;
        k = i - fcs0;
        b = f.pattern[7:0];
        if (i < IDX_SA) begin
            if (f.bcast) begin
                b = BCAST_BYTE;
            end else if (i == IDX_DA_LAST) begin
                b = da;
            end else begin
                b = m[i[2:0]];
            end
        end else if (i < IDX_TYPE_HI) begin
            b = m[3'(i - IDX_SA)];
        end else if (i == IDX_TYPE_HI) begin
            b = TYPE_HI;
        end else if (i == IDX_TYPE_LO) begin
            b = TYPE_LO;
        end else if (i == fcs0) begin
            b = ~c_nxt[7:0];
        end else if (i > fcs0) begin
            b = ~c_reg[{k[1:0], 3'b000} +: 8];
        end else if (i[0] == 1'b0) begin
            b = f.pattern[15:8];
        end
        return b;
    endfunction

    assign sel_fmt = decode_sel(s_r.pattern_sel);
    assign last_idx = frame_len(s_r.fmt) - 11'h001;
    assign last_data_idx = frame_len(s_r.fmt) - FCS_BYTES - 11'h001;
    assign hs = (s_r.st == ST_SEND) && tx_ready;
    // A nonzero write to the setup register launches a burst in center mode when idle and the selector code is valid.
    assign start = reg_wr && (reg_addr == ADDR_SETUP1) && (reg_wdata != CNT_ZERO) && s_r.center
                   && (s_r.st == ST_IDLE) && sel_fmt.valid;
    assign clear_cnt = reg_wr && (reg_addr == ADDR_SETUP1) && (reg_wdata == CNT_ZERO);
    assign crc_event = rx_frame_done && rx_crc_err && s_r.center;
    assign crc_init = start || (hs && (s_r.idx == last_idx));
    assign crc_en = hs && (s_r.idx <= last_data_idx);

    frame_crc32 u_crc (
        .clock(clock),
        .resetn(resetn),
        .init(crc_init),
        .en(crc_en),
        .data(s_r.data),
        .crc_r(crc_r),
        .crc_nxt(crc_nxt)
    );

    // Register file, error counter and frame sequencer in one next-state process.
    always_comb begin
        s_nxt = s_r;
        s_nxt.center_meta = center_mode;
        s_nxt.center = s_r.center_meta;
        s_nxt.rvalid = reg_rd;
        if (reg_wr) begin
            if (reg_addr == ADDR_SETUP1) begin
                s_nxt.setup1 = reg_wdata;
            end else if (reg_addr == ADDR_PATTERN) begin
                s_nxt.pattern_sel = reg_wdata;
            end else if ((reg_addr >= ADDR_MAC0) && (reg_addr <= ADDR_MAC5)) begin
                s_nxt.mac[3'(reg_addr - ADDR_MAC0)] = reg_wdata;
            end
        end
        // Reads answer one cycle later; unmapped numbers read as zero.
        if (reg_rd) begin
            s_nxt.rdata = CNT_ZERO;
            if (reg_addr == ADDR_SETUP1) begin
                s_nxt.rdata = s_r.setup1;
            end else if (reg_addr == ADDR_PATTERN) begin
                s_nxt.rdata = s_r.pattern_sel;
            end else if (reg_addr == ADDR_CRC_CNT) begin
                s_nxt.rdata = s_r.crc_cnt;
            end else if ((reg_addr >= ADDR_MAC0) && (reg_addr <= ADDR_MAC5)) begin
                s_nxt.rdata = s_r.mac[3'(reg_addr - ADDR_MAC0)];
            end
        end
        // A clear and an error in the same cycle leave a count of one, so no event is lost.
        if (clear_cnt) begin
            s_nxt.crc_cnt = CNT_ZERO;
        end
        if (crc_event && (s_nxt.crc_cnt != CNT_MAX)) begin
            s_nxt.crc_cnt = s_nxt.crc_cnt + 8'h01;
        end
        unique case (s_r.st)
            ST_IDLE: begin
                if (start) begin
                    s_nxt.st = ST_SEND;
                    s_nxt.fmt = sel_fmt;
                    s_nxt.frames_left = reg_wdata;
                    s_nxt.da_last = s_r.mac[5] + 8'h01;
                    s_nxt.idx = '0;
                    s_nxt.data = frame_byte('0, sel_fmt, s_r.mac, s_r.mac[5] + 8'h01, crc_nxt, crc_r);
                end
            end
            ST_SEND: begin
                if (hs) begin
                    if (s_r.idx == last_idx) begin
                        s_nxt.frames_left = s_r.frames_left - 8'h01;
                        s_nxt.da_last = s_r.da_last + 8'h01;
                        s_nxt.idx = '0;
                        s_nxt.data = frame_byte('0, s_r.fmt, s_r.mac, s_r.da_last + 8'h01, crc_nxt, crc_r);
                        if (s_r.frames_left == 8'h01) begin
                            s_nxt.st = ST_IDLE;
                        end
                    end else begin
                        s_nxt.idx = s_r.idx + 11'h001;
                        s_nxt.data = frame_byte(s_r.idx + 11'h001, s_r.fmt, s_r.mac, s_r.da_last, crc_nxt, crc_r);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_r <= '{center_meta: 1'b0, center: 1'b0, setup1: SETUP1_RESET, pattern_sel: PATTERN_RESET,
                     crc_cnt: CNT_ZERO, mac: {6{MAC_RESET}}, rdata: CNT_ZERO, rvalid: 1'b0,
                     st: ST_IDLE, fmt: '0, idx: '0, frames_left: CNT_ZERO, da_last: CNT_ZERO,
                     data: CNT_ZERO};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs; valid and the frame markers derive from registered state only.
    assign reg_rdata = s_r.rdata;
    assign reg_rvalid = s_r.rvalid;
    assign tx_data = s_r.data;
    assign tx_valid = (s_r.st == ST_SEND);
    assign tx_sof = tx_valid && (s_r.idx == '0);
    assign tx_eof = tx_valid && (s_r.idx == last_idx);
    assign busy = tx_valid;

    sequence s_last_hs;
        tx_valid && tx_ready && tx_eof;
    endsequence

    sequence s_clear_only;
        clear_cnt && !crc_event;
    endsequence

    property p_sel_reset;
        @(posedge clock) !resetn |=> (s_r.pattern_sel == PATTERN_RESET) && (s_r.crc_cnt == CNT_ZERO);
    endproperty
    a_sel_reset: assert property (p_sel_reset) else $error("selector or counter not zero after reset");

    property p_cnt_inc;
        @(posedge clock) disable iff (!resetn)
        crc_event && !clear_cnt && (s_r.crc_cnt != CNT_MAX) |=> s_r.crc_cnt == $past(s_r.crc_cnt) + 8'h01;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("error counter missed an increment");

    property p_cnt_sat;
        @(posedge clock) disable iff (!resetn)
        (s_r.crc_cnt == CNT_MAX) && !clear_cnt |=> s_r.crc_cnt == CNT_MAX;
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("error counter wrapped");

    property p_cnt_clear;
        @(posedge clock) disable iff (!resetn)
        s_clear_only |=> s_r.crc_cnt == CNT_ZERO;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("error counter not cleared");

    property p_type;
        @(posedge clock) disable iff (!resetn)
        tx_valid && tx_ready && (s_r.idx == IDX_TYPE_HI) |-> tx_data == TYPE_HI ##1 (tx_data == TYPE_LO) [*1];
    endproperty
    a_type: assert property (p_type) else $error("type field wrong");

    property p_bcast;
        @(posedge clock) disable iff (!resetn)
        tx_valid && s_r.fmt.bcast && (s_r.idx < IDX_SA) |-> tx_data == BCAST_BYTE;
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast destination wrong");

    property p_da_step;
        @(posedge clock) disable iff (!resetn)
        s_last_hs ##0 (s_r.frames_left != 8'h01) |=> s_r.da_last == $past(s_r.da_last) + 8'h01;
    endproperty
    a_da_step: assert property (p_da_step) else $error("destination byte did not step");

    property p_len;
        @(posedge clock) disable iff (!resetn)
        s_last_hs |-> s_r.idx == (s_r.fmt.long_frame ? LEN_LONG - 11'h001 : LEN_SHORT - 11'h001);
    endproperty
    a_len: assert property (p_len) else $error("frame length wrong");

    property p_burst;
        @(posedge clock) disable iff (!resetn)
        start |=> tx_valid && tx_sof && (s_r.frames_left == $past(reg_wdata));
    endproperty
    a_burst: assert property (p_burst) else $error("burst count not taken");
endmodule

// >>> test/loopback_partner.sv
// Purpose: Far-side converter model that takes test frames and returns them.
// Assumes: Inputs from the bench are sampled on the rising edge of clock.
// Notes: Each frame whose last byte is taken comes back one cycle later.
`timescale 1ns/1ps
module loopback_partner (
    input wire logic clock,
    input wire logic tx_valid,
    input wire logic tx_eof,
    input wire logic stall,
    input wire logic inj,
    input wire logic err_req,
    output logic tx_ready,
    output logic rx_frame_done,
    output logic rx_crc_err
);
    logic ev;
    logic err;

    // Idle values at time zero, before the first edge.
    initial begin
        tx_ready = 1'b1;
        rx_frame_done = 1'b0;
        rx_crc_err = 1'b0;
    end

    // Sample at the edge, answer just after it; the error flag is noise between returns.
    always @(posedge clock) begin
        ev = (tx_valid && tx_ready && tx_eof) || inj;
        err = err_req;
        #1;
        tx_ready = !stall || ($urandom_range(3) != 0);
        rx_frame_done = ev;
        rx_crc_err = ev ? err : 1'($urandom_range(1));
    end
endmodule

// >>> test/loopback_test_frames_tb.sv
// Purpose: Self-checking bench for the loopback test frame block.
// Assumes: Broadcast frames carry an all-ones destination address.
// Notes: A reference model builds every expected byte, FCS included.
`timescale 1ns/1ps
module loopback_test_frames_tb;
    import loopback_pkg::*;
    logic clock, resetn, center_mode, reg_wr, reg_rd, tx_valid, tx_sof, tx_eof, tx_ready;
    logic reg_rvalid, rx_frame_done, rx_crc_err, busy, stall, inj, err_req;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data;
    logic [7:0] mac [6];
    logic [7:0] codes [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    logic [9:0] exp_q [$];
    int cnt_exp, num_errors, comparisons, i, n;
    wire clr = reg_wr && reg_addr == 8'h44 && reg_wdata == 8'h00;

    loopback_test_frames uut (.clock(clock), .resetn(resetn), .center_mode(center_mode),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_sof(tx_sof), .tx_eof(tx_eof), .tx_ready(tx_ready), .rx_frame_done(rx_frame_done),
        .rx_crc_err(rx_crc_err), .busy(busy));
    loopback_partner far (.clock(clock), .tx_valid(tx_valid), .tx_eof(tx_eof), .stall(stall),
        .inj(inj), .err_req(err_req), .tx_ready(tx_ready), .rx_frame_done(rx_frame_done),
        .rx_crc_err(rx_crc_err));

    // Free-running 200 MHz clock.
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Bus tasks start and end one time unit after an edge; an edge passes between strobes.
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock) #1;
        reg_wr = 1'b0;
        @(posedge clock) #1;
    endtask

    task rdc(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock) #1;
        reg_rd = 1'b0;
        check("reg_rvalid", {15'h0, reg_rvalid}, 16'h0001);
        check("reg_rdata", {8'h00, reg_rdata}, {8'h00, e});
        @(posedge clock) #1;
    endtask

    task cycles(input int k);
        repeat (k) @(posedge clock) #1;
    endtask

    // Reflected CRC-32, one byte at a time.
    function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
        int j;
        c = c ^ {24'h000000, b};
        for (j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
        return c;
    endfunction

    // Queue every byte of a burst as {eof, sof, data}.
    task automatic push_frames(input logic [7:0] code, input int cnt);
        int len, k, f;
        logic [31:0] c;
        logic [7:0] b;
        logic [15:0] pat;
        logic bc;
        len = (code inside {8'h01, 8'h04, 8'h10, 8'h40, 8'h80}) ? 1518 : 64;
        bc = code inside {8'h02, 8'h04, 8'h40, 8'h80};
        pat = (code <= 8'h04) ? 16'h55AA : ((code == 8'h80) ? 16'hFF00 : 16'h0F0F);
        for (f = 0; f < cnt; f++) begin
            c = 32'hFFFFFFFF;
            for (k = 0; k < len; k++) begin
                if (k < 6) b = bc ? 8'hFF : ((k == 5) ? 8'(mac[5] + f + 1) : mac[k]);
                else if (k < 12) b = mac[k - 6];
                else if (k < 14) b = (k == 12) ? 8'h08 : 8'h00;
                else if (k < len - 4) b = ((k - 14) % 2 == 0) ? pat[15:8] : pat[7:0];
                else b = 8'(~c >> (8 * (k - len + 4)));
                if (k < len - 4) c = crc8(c, b);
                exp_q.push_back({k == len - 1, k == 0, b});
            end
        end
    endtask

    // Compare each taken byte and track the error counter; a clear with a same-cycle error leaves a count of one.
    always @(posedge clock) begin
        if (tx_valid === 1'b1 && tx_ready) begin
            if (exp_q.size() == 0) check("tx_extra", 16'h0000, 16'hFFFF);
            else check("tx_byte", {6'h00, tx_eof, tx_sof, tx_data}, {6'h00, exp_q.pop_front()});
        end
        if (rx_frame_done && rx_crc_err && center_mode) cnt_exp = clr ? 1 : ((cnt_exp == 255) ? 255 : cnt_exp + 1);
        else if (clr) cnt_exp = 0;
    end

    task wait_idle();
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 20000) begin
            @(posedge clock) #1;
            t++;
        end
        cycles(3);
        check("busy_end", {15'h0, busy}, 16'h0000);
        check("q_left", 16'(exp_q.size()), 16'h0000);
    endtask

    task inject(input int k);
        inj = 1'b1;
        cycles(k);
        inj = 1'b0;
        cycles(3);
    endtask

    // Watchdog at about twice the expected run of some 23k cycles, so a hang still ends well under budget.
    initial begin
        #250000;
        num_errors++;
        finish_test();
    end

    // Main sequence: reset values, every selector code, refusals, counter clear and saturation.
    initial begin
        {reg_wr, reg_rd, stall, inj, err_req, resetn} = 6'h00;
        {reg_addr, reg_wdata} = 16'h0000;
        center_mode = 1'b1;
        cnt_exp = 0;
        void'($urandom(32'hB18ECA08));
        repeat (20) @(posedge clock);
        #1;
        resetn = 1'b1;
        cycles(3);
        rdc(8'h44, 8'h07);
        rdc(8'h45, 8'h00);
        rdc(8'h46, 8'h00);
        rdc(8'h99, 8'h00);
        wr(8'h46, 8'hA5);
        rdc(8'h46, 8'h00);
        for (i = 0; i < 6; i++) begin
            mac[i] = (i == 5) ? 8'hFE : 8'($urandom);
            wr(8'(8'h52 + i), mac[i]);
        end
        rdc(8'h57, 8'hFE);
        stall = 1'b1;
        for (i = 0; i < 9; i++) begin
            wr(8'h45, codes[i]);
            rdc(8'h45, codes[i]);
            err_req = i[0];
            n = 1 + i % 3;
            push_frames(codes[i], n);
            wr(8'h44, 8'(n));
            wait_idle();
            rdc(8'h46, 8'(cnt_exp));
        end
        wr(8'h45, 8'h03);
        wr(8'h44, 8'h01);
        cycles(20);
        check("busy_undef", {15'h0, busy}, 16'h0000);
        wr(8'h44, 8'h00);
        rdc(8'h46, 8'h00);
        center_mode = 1'b0;
        cycles(5);
        wr(8'h45, 8'h00);
        wr(8'h44, 8'h01);
        cycles(20);
        check("busy_term", {15'h0, busy}, 16'h0000);
        err_req = 1'b1;
        inject(5);
        rdc(8'h46, 8'h00);
        center_mode = 1'b1;
        cycles(5);
        inject(3);
        rdc(8'h46, 8'h03);
        inject(258);
        rdc(8'h46, 8'hFF);
        finish_test();
    end
endmodule
